//--- hw/ppo_port_end.sv
// port pin logic: registers, overrides, sleep clamp, pad and interrupts
`timescale 1ns/100ps
`default_nettype none
module ppo_port_end (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // avalon-mm slave
    input wire logic [ppo_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // sleep controller and interrupt
    input wire logic sleep_clamp,
    output logic irq,
    // pads
    input wire ppo_pkg::ppo_pins_t pad_in,
    output ppo_pkg::ppo_pins_t pad_out,
    output ppo_pkg::ppo_pins_t pad_oe_n,
    output ppo_pkg::ppo_pins_t pad_pullup_en,
    // alternate functions
    ppo_override_if.port_end ovr
);
    import ppo_pkg::*;

    ppo_pins_t dir_reg;
    ppo_pins_t drive_reg;
    ppo_pins_t pin_in_reg;
    ppo_pins_t pin_prev_reg;
    ppo_pins_t irq_status_reg;
    ppo_pins_t irq_status_next;
    ppo_pins_t irq_mask_reg;
    logic [15:0] sense_reg;
    logic [7:0] sfc_reg;
    logic ack_reg;
    logic [31:0] rdata_next;
    ppo_pins_t sync_latch;
    ppo_pins_t input_enable;
    ppo_pins_t digital_in;
    ppo_pins_t drv_en;
    ppo_pins_t pin_event;
    logic wr_en;
    logic pullup_disable;

    // ****************************************
    // bus handshake: one wait state per access
    // ****************************************
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (avs_read | avs_write) & ~ack_reg;
        end
    end

    assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
    assign wr_en = avs_write & ack_reg;
    assign pullup_disable = sfc_reg[SFC_PULLUP_DISABLE_BIT];

    // ****************************************
    // port registers
    // ****************************************
    // one strobe for all pins
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            dir_reg <= PINS_RESET;
        end else if (wr_en && avs_address == OFS_DIRECTION) begin
            dir_reg <= avs_writedata[PIN_COUNT-1:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            drive_reg <= PINS_RESET;
        end else if (wr_en && avs_address == OFS_DRIVE) begin
            drive_reg <= avs_writedata[PIN_COUNT-1:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sfc_reg <= SFC_RESET;
        end else if (wr_en && avs_address == OFS_SPECIAL) begin
            sfc_reg <= avs_writedata[7:0] & SFC_WRITE_MASK;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            irq_mask_reg <= PINS_RESET;
        end else if (wr_en && avs_address == OFS_IRQ_MASK) begin
            irq_mask_reg <= avs_writedata[PIN_COUNT-1:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sense_reg <= SENSE_RESET;
        end else if (wr_en && avs_address == OFS_SENSE) begin
            sense_reg <= avs_writedata[15:0];
        end
    end

    // ****************************************
    // per-pin pad logic
    // ****************************************
    for (genvar n = 0; n < PIN_COUNT; n++) begin : g_pin
        assign drv_en[n] = ovr.direction_override_enable[n] ?
            ovr.direction_override_value[n] : dir_reg[n];
        assign pad_oe_n[n] = ~(drv_en[n] & rst_n);
        assign pad_out[n] = ovr.pin_value_override_enable[n] ?
            ovr.pin_value_override_value[n] : drive_reg[n];
        assign pad_pullup_en[n] = rst_n & (ovr.pullup_override_enable[n] ?
            ovr.pullup_override_value[n] :
            ({dir_reg[n], drive_reg[n], pullup_disable} ==
            PULLUP_ON_PATTERN));
        assign input_enable[n] = ovr.input_enable_override_enable[n] ?
            ovr.input_enable_override_value[n] :
            ~(sleep_clamp & ~irq_mask_reg[n]);
        assign digital_in[n] = pad_in[n] & input_enable[n];
        assign pin_event[n] = (sense_reg[2*n +: 2] == SENSE_ANY) ?
            (pin_in_reg[n] ^ pin_prev_reg[n]) :
            (sense_reg[2*n +: 2] == SENSE_FALL) ?
            (~pin_in_reg[n] & pin_prev_reg[n]) :
            (sense_reg[2*n +: 2] == SENSE_RISE) ?
            (pin_in_reg[n] & ~pin_prev_reg[n]) : 1'b0;
    end

    assign ovr.alt_function_digital_in = digital_in;

    // ****************************************
    // input synchroniser
    // ****************************************
    // latch open while clock high
    always_latch begin
        if (ref_clk) begin
            sync_latch <= digital_in;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pin_in_reg <= PINS_RESET;
            pin_prev_reg <= PINS_RESET;
        end else begin
            pin_in_reg <= sync_latch;
            pin_prev_reg <= pin_in_reg;
        end
    end

    // ****************************************
    // interrupt flags
    // ****************************************
    // set wins over clear
    always_comb begin
        irq_status_next = irq_status_reg;
        if (wr_en && avs_address == OFS_IRQ_STATUS) begin
            irq_status_next = irq_status_next &
                ~avs_writedata[PIN_COUNT-1:0];
        end
        irq_status_next = irq_status_next | pin_event;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            irq_status_reg <= PINS_RESET;
        end else begin
            irq_status_reg <= irq_status_next;
        end
    end

    assign irq = |(irq_status_reg & irq_mask_reg);

    // ****************************************
    // read data
    // ****************************************
    always_comb begin
        rdata_next = 32'h0000_0000;
        unique case (avs_address)
            OFS_DIRECTION: rdata_next[PIN_COUNT-1:0] = dir_reg;
            OFS_DRIVE: rdata_next[PIN_COUNT-1:0] = drive_reg;
            OFS_INPUT: rdata_next[PIN_COUNT-1:0] = pin_in_reg;
            OFS_SPECIAL: rdata_next[7:0] = sfc_reg;
            OFS_IRQ_STATUS: rdata_next[PIN_COUNT-1:0] = irq_status_reg;
            OFS_IRQ_MASK: rdata_next[PIN_COUNT-1:0] = irq_mask_reg;
            OFS_SENSE: rdata_next[15:0] = sense_reg;
            default: rdata_next = 32'h0000_0000;
        endcase
    end

    // captured in the wait cycle, stands at the release edge
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && !ack_reg) begin
            avs_readdata <= rdata_next;
        end
    end
endmodule
`default_nettype wire

//--- hw/ppo_pkg.sv
// constants and types shared by both ends of the pin override logic
package ppo_pkg;
    localparam int PIN_COUNT = 8;
    typedef logic [PIN_COUNT-1:0] ppo_pins_t;

    // ****************************************
    // register byte addresses
    // ****************************************
    localparam int ADDR_W = 5;
    localparam logic [ADDR_W-1:0] OFS_DIRECTION = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_DRIVE = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_INPUT = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_SPECIAL = 5'h0c;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 5'h10;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 5'h14;
    localparam logic [ADDR_W-1:0] OFS_SENSE = 5'h18;

    // ****************************************
    // fields and reset values
    // ****************************************
    localparam int SFC_PULLUP_DISABLE_BIT = 2;
    localparam logic [7:0] SFC_WRITE_MASK = 8'hef;
    localparam logic [7:0] SFC_RESET = 8'h00;
    localparam logic [7:0] PINS_RESET = 8'h00;
    localparam logic [15:0] SENSE_RESET = 16'h0000;
    localparam logic [2:0] PULLUP_ON_PATTERN = 3'b010;

    // ****************************************
    // edge sense per pin, two bits each
    // ****************************************
    typedef enum logic [1:0] {
        SENSE_OFF = 2'b00,
        SENSE_ANY = 2'b01,
        SENSE_FALL = 2'b10,
        SENSE_RISE = 2'b11
    } ppo_sense_e;
endpackage

//--- hw/ppo_override_if.sv
// override signals between port pin logic and alternate-function owners
`timescale 1ns/100ps
`default_nettype none
interface ppo_override_if;
    import ppo_pkg::*;
    ppo_pins_t pullup_override_enable;
    ppo_pins_t pullup_override_value;
    ppo_pins_t direction_override_enable;
    ppo_pins_t direction_override_value;
    ppo_pins_t pin_value_override_enable;
    ppo_pins_t pin_value_override_value;
    ppo_pins_t input_enable_override_enable;
    ppo_pins_t input_enable_override_value;
    ppo_pins_t alt_function_digital_in;

    modport port_end (
        input pullup_override_enable, pullup_override_value,
        input direction_override_enable, direction_override_value,
        input pin_value_override_enable, pin_value_override_value,
        input input_enable_override_enable, input_enable_override_value,
        output alt_function_digital_in
    );
    modport periph_end (
        output pullup_override_enable, pullup_override_value,
        output direction_override_enable, direction_override_value,
        output pin_value_override_enable, pin_value_override_value,
        output input_enable_override_enable, input_enable_override_value,
        input alt_function_digital_in
    );
endinterface
`default_nettype wire

//--- hw/ppo_periph_end.sv
// alternate-function owner: makes overrides, synchronises digital input
`timescale 1ns/100ps
`default_nettype none
module ppo_periph_end (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // pin interface
    ppo_override_if.periph_end ovr,
    // function requests per pin
    input wire ppo_pkg::ppo_pins_t alt_enable,
    input wire ppo_pkg::ppo_pins_t alt_drive_out,
    input wire ppo_pkg::ppo_pins_t alt_out_value,
    input wire ppo_pkg::ppo_pins_t alt_pullup_force,
    input wire ppo_pkg::ppo_pins_t alt_pullup_value,
    input wire ppo_pkg::ppo_pins_t alt_keep_input_awake,
    // received input
    output ppo_pkg::ppo_pins_t alt_in_raw,
    output ppo_pkg::ppo_pins_t alt_in_sync
);
    import ppo_pkg::*;

    ppo_pins_t sync1_reg;
    ppo_pins_t sync2_reg;
    ppo_pins_t dir_oe_reg, dir_ov_reg, val_oe_reg, val_ov_reg;
    ppo_pins_t pu_oe_reg, pu_ov_reg, ie_oe_reg;

    // ****************************************
    // override generation
    // ****************************************
    // owner makes overrides
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            dir_oe_reg <= PINS_RESET;
            dir_ov_reg <= PINS_RESET;
            val_oe_reg <= PINS_RESET;
            val_ov_reg <= PINS_RESET;
            pu_oe_reg <= PINS_RESET;
            pu_ov_reg <= PINS_RESET;
            ie_oe_reg <= PINS_RESET;
        end else begin
            dir_oe_reg <= alt_enable;
            dir_ov_reg <= alt_enable & alt_drive_out;
            val_oe_reg <= alt_enable & alt_drive_out;
            val_ov_reg <= alt_enable & alt_out_value;
            pu_oe_reg <= alt_enable & alt_pullup_force;
            pu_ov_reg <= alt_enable & alt_pullup_force & alt_pullup_value;
            ie_oe_reg <= alt_enable & alt_keep_input_awake;
        end
    end

    assign ovr.direction_override_enable = dir_oe_reg;
    assign ovr.direction_override_value = dir_ov_reg;
    assign ovr.pin_value_override_enable = val_oe_reg;
    assign ovr.pin_value_override_value = val_ov_reg;
    assign ovr.pullup_override_enable = pu_oe_reg;
    assign ovr.pullup_override_value = pu_ov_reg;
    assign ovr.input_enable_override_enable = ie_oe_reg;
    assign ovr.input_enable_override_value = ie_oe_reg;

    // ****************************************
    // input synchroniser
    // ****************************************
    // own two-stage synchroniser
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sync1_reg <= PINS_RESET;
            sync2_reg <= PINS_RESET;
        end else begin
            sync1_reg <= ovr.alt_function_digital_in;
            sync2_reg <= sync1_reg;
        end
    end

    // raw path kept for use as a clock source only
    assign alt_in_raw = ovr.alt_function_digital_in;
    assign alt_in_sync = sync2_reg;
endmodule
`default_nettype wire

//--- bench/ppo_properties.sv
// concurrent checks on the bus handshake, pads and override link
`timescale 1ns/100ps
`default_nettype none
module ppo_properties (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // bus handshake
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    // sleep and pads
    input wire logic sleep_clamp,
    input wire ppo_pkg::ppo_pins_t pad_in,
    input wire ppo_pkg::ppo_pins_t pad_out,
    input wire ppo_pkg::ppo_pins_t pad_oe_n,
    input wire ppo_pkg::ppo_pins_t pad_pullup_en,
    // override link
    input wire ppo_pkg::ppo_pins_t pullup_override_enable,
    input wire ppo_pkg::ppo_pins_t pullup_override_value,
    input wire ppo_pkg::ppo_pins_t direction_override_enable,
    input wire ppo_pkg::ppo_pins_t direction_override_value,
    input wire ppo_pkg::ppo_pins_t pin_value_override_enable,
    input wire ppo_pkg::ppo_pins_t pin_value_override_value,
    input wire ppo_pkg::ppo_pins_t input_enable_override_enable,
    input wire ppo_pkg::ppo_pins_t input_enable_override_value,
    input wire ppo_pkg::ppo_pins_t alt_function_digital_in
);
    import ppo_pkg::*;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    // ********
    // bus handshake
    // ********
    sequence s_req_wait;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_req_ack;
        (avs_read || avs_write) && !avs_waitrequest;
    endsequence
    AST_ONE_WAIT_STATE: assert property (s_req_wait |=> s_req_ack)
        else $error("request not answered after one wait state");
    AST_IDLE_READY: assert property (
        !(avs_read || avs_write) |-> !avs_waitrequest)
        else $error("waitrequest high without a request");

    // ********
    // pads and overrides
    // ********
    AST_RESET_SAFE: assert property (disable iff (1'b0)
        !rst_n |-> (pad_oe_n == '1) && (pad_pullup_en == '0))
        else $error("pad driven or pulled up during reset");
    AST_PULLUP_OVERRIDE: assert property (|pullup_override_enable |->
        ((pad_pullup_en ^ pullup_override_value)
        & pullup_override_enable) == '0)
        else $error("pull-up ignores its override");
    AST_DIRECTION_OVERRIDE: assert property (
        |direction_override_enable |-> ((~pad_oe_n ^ direction_override_value)
        & direction_override_enable) == '0)
        else $error("driver enable ignores its override");
    AST_VALUE_OVERRIDE: assert property (
        |(pin_value_override_enable & ~pad_oe_n) |->
        ((pad_out ^ pin_value_override_value) & pin_value_override_enable
        & ~pad_oe_n) == '0)
        else $error("driven level ignores its override");
    AST_INPUT_OVERRIDE: assert property (
        |input_enable_override_enable |-> ((alt_function_digital_in
        ^ (pad_in & input_enable_override_value))
        & input_enable_override_enable) == '0)
        else $error("input enable ignores its override");
    AST_AWAKE_INPUT: assert property (
        !sleep_clamp |-> ((alt_function_digital_in ^ pad_in)
        & ~input_enable_override_enable) == '0)
        else $error("digital input differs from pad while awake");
    AST_PULLUP_INPUT_ONLY: assert property (
        |pad_pullup_en |-> (pad_pullup_en & ~pullup_override_enable
        & ~direction_override_enable & ~pad_oe_n) == '0)
        else $error("register pull-up on a driven pin");
endmodule
`default_nettype wire

//--- bench/port_pin_override_logic_tb_top.sv
// testbench joining both ends of the pin override logic
`timescale 1ns/100ps
`default_nettype none
module port_pin_override_logic_tb_top;
    import ppo_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [ADDR_W-1:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = '0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic sleep_clamp = 1'b0;
    logic irq;
    logic flt = 1'b0;
    ppo_pins_t pad_in, pad_out, pad_oe_n, pad_pullup_en, alt_in_raw, d;
    ppo_pins_t alt_in_sync;
    ppo_pins_t ext_en = '0;
    ppo_pins_t ext_val = '0;
    ppo_pins_t alt_v[6] = '{default: '0};
    logic [31:0] exp_q[$];
    int error_cnt = 0;
    int n_checks = 0;

    // ********
    // pads, clock and both ends
    // ********
    // released pins without a pull-up or external drive wander instead of holding a value
    assign pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & ext_en & ext_val)
        | (pad_oe_n & ~ext_en & (pad_pullup_en | {PIN_COUNT{flt}}));
    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) flt <= ~flt;
    ppo_override_if u_ppo_override_if ();
    ppo_port_end u_ppo_port_end (.ref_clk, .rst_n, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
        .sleep_clamp, .irq, .pad_in, .pad_out, .pad_oe_n, .pad_pullup_en,
        .ovr(u_ppo_override_if.port_end));
    ppo_periph_end u_ppo_periph_end (.ref_clk, .rst_n,
        .ovr(u_ppo_override_if.periph_end), .alt_enable(alt_v[0]),
        .alt_drive_out(alt_v[1]), .alt_out_value(alt_v[2]),
        .alt_pullup_force(alt_v[3]), .alt_pullup_value(alt_v[4]),
        .alt_keep_input_awake(alt_v[5]), .alt_in_raw, .alt_in_sync);
    ppo_properties u_ppo_properties (.ref_clk, .rst_n, .avs_read, .avs_write,
        .avs_waitrequest, .sleep_clamp, .pad_in, .pad_out, .pad_oe_n,
        .pad_pullup_en,
        .pullup_override_enable(u_ppo_override_if.pullup_override_enable),
        .pullup_override_value(u_ppo_override_if.pullup_override_value),
        .direction_override_enable(u_ppo_override_if.direction_override_enable),
        .direction_override_value(u_ppo_override_if.direction_override_value),
        .pin_value_override_enable(u_ppo_override_if.pin_value_override_enable),
        .pin_value_override_value(u_ppo_override_if.pin_value_override_value),
        .input_enable_override_enable(
            u_ppo_override_if.input_enable_override_enable),
        .input_enable_override_value(
            u_ppo_override_if.input_enable_override_value),
        .alt_function_digital_in(u_ppo_override_if.alt_function_digital_in));

    // ********
    // tasks
    // ********
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done(string s);
        $display("test %s done, %0d mismatches", s, error_cnt);
    endtask
    task automatic bus(logic w, logic [ADDR_W-1:0] a, logic [31:0] wd);
        int n;
        n = 0;
        @(posedge ref_clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= wd;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (n >= 20) begin
            error_cnt++;
            end_of_test();
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(logic [ADDR_W-1:0] a, logic [31:0] wd);
        bus(1'b1, a, wd);
    endtask
    task automatic rd(logic [ADDR_W-1:0] a, logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, '0);
    endtask
    task automatic do_reset();
        rst_n <= 1'b0;
        @(negedge ref_clk);
        check("oe_n in reset", 32'(pad_oe_n), 32'hff);
        check("pull-up in reset", 32'(pad_pullup_en), 32'h0);
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
    endtask
    // read results are compared as they appear
    always @(negedge ref_clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            if (exp_q.size() == 0) check("read queue", 32'h1, 32'h0);
            else check($sformatf("read %h", avs_address), avs_readdata,
                exp_q.pop_front());
        end
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        error_cnt++;
        end_of_test();
    end

    // ********
    // scenarios
    // ********
    initial begin
        void'($urandom(23998));
        do_reset();
        rd(OFS_DIRECTION, 32'h0);
        rd(OFS_DRIVE, 32'h0);
        rd(OFS_SPECIAL, 32'(SFC_RESET));
        rd(5'h1c, 32'h0);
        test_done("reset values");
        d = ppo_pins_t'($urandom);
        wr(OFS_DRIVE, 32'(d));
        wr(OFS_DIRECTION, 32'hff);
        @(negedge ref_clk);
        check("oe_n", 32'(pad_oe_n), 32'h0);
        check("pad_out", 32'(pad_out), 32'(d));
        rd(OFS_INPUT, 32'(d));
        test_done("outputs");
        d = ppo_pins_t'($urandom);
        ext_en <= ~d;
        wr(OFS_DIRECTION, 32'h0);
        wr(OFS_DRIVE, 32'(d));
        @(negedge ref_clk);
        check("pull-up", 32'(pad_pullup_en), 32'(d));
        rd(OFS_INPUT, 32'(d));
        wr(OFS_SPECIAL, 32'hff);
        rd(OFS_SPECIAL, 32'(SFC_WRITE_MASK));
        @(negedge ref_clk);
        check("pull-up disabled", 32'(pad_pullup_en), 32'h0);
        wr(OFS_SPECIAL, 32'h0);
        test_done("pull-ups");
        ext_en <= 8'hff;
        wr(OFS_IRQ_MASK, 32'h0);
        for (int i = 0; i < 4; i++) begin
            wr(OFS_SENSE, 32'({8{i[1:0]}}));
            wr(OFS_IRQ_STATUS, 32'hff);
            ext_val <= 8'h01;
            repeat (4) @(posedge ref_clk);
            rd(OFS_IRQ_STATUS, 32'(i == 1 || i == 3));
            wr(OFS_IRQ_STATUS, 32'hff);
            ext_val <= 8'h00;
            repeat (4) @(posedge ref_clk);
            rd(OFS_IRQ_STATUS, 32'(i == 1 || i == 2));
        end
        ext_val <= 8'h01;
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk);
        check("irq masked", 32'(irq), 32'h0);
        wr(OFS_IRQ_MASK, 32'h1);
        @(negedge ref_clk);
        check("irq", 32'(irq), 32'h1);
        test_done("edge sense");
        for (int m = 0; m < 2; m++) begin
            wr(OFS_IRQ_MASK, 32'(m));
            wr(OFS_IRQ_STATUS, 32'hff);
            sleep_clamp <= 1'b1;
            repeat (4) @(posedge ref_clk);
            @(negedge ref_clk);
            check("sleep input", 32'(alt_in_raw), 32'(m));
            check("sleep sync", 32'(alt_in_sync), 32'(m));
            rd(OFS_INPUT, 32'(m));
            wr(OFS_IRQ_STATUS, 32'hff);
            sleep_clamp <= 1'b0;
            repeat (4) @(posedge ref_clk);
            rd(OFS_IRQ_STATUS, 32'(1 - m));
        end
        test_done("sleep clamp");
        for (int i = 0; i < 300; i++) begin
            @(posedge ref_clk);
            foreach (alt_v[k]) alt_v[k] <= ppo_pins_t'($urandom);
            ext_en <= ppo_pins_t'($urandom);
            ext_val <= ppo_pins_t'($urandom);
            sleep_clamp <= 1'($urandom);
        end
        @(posedge ref_clk);
        foreach (alt_v[k]) alt_v[k] <= (k < 3) ? 8'h01 : 8'h00;
        sleep_clamp <= 1'b0;
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        check("override oe_n", 32'(pad_oe_n), 32'hfe);
        check("override out", 32'(pad_out[0]), 32'h1);
        @(posedge ref_clk);
        alt_v[0] <= 8'h00;
        ext_en <= 8'h0f;
        wr(OFS_DIRECTION, 32'h0f);
        wr(OFS_DRIVE, 32'hf0);
        do_reset();
        rd(OFS_DIRECTION, 32'h0);
        test_done("overrides and reset");
        end_of_test();
    end
endmodule
`default_nettype wire
